/* pkg/retop_pkg.sv */
// Constants shared by the return and option-load decoder.
// Assumes a 14-bit instruction word and an 8-bit data path.
package retop_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  // Full opcode patterns
  localparam logic [13:0] OPC_RETURN_FROM_IRQ = 14'h0009;
  localparam logic [13:0] OPC_LOAD_OPTION = 14'h0062;
  // Return-with-literal: top two bits 11, next two 01, two don't-care bits
  localparam logic [3:0] OPC_RETLIT_HI = 4'hD;
  localparam int RETLIT_HI_POS = 10;
  localparam int LIT_LSB = 0;
  // Global enable position in the interrupt control register
  localparam int IRQ_EN_BIT = 7;
  // Cycle counts
  localparam int RET_CYCLES = 2;
  // Reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  // Data-memory address of the option register
  localparam logic [7:0] OPTION_ADDR = 8'h81;
endpackage : retop_pkg

/* core/opcode_classify.sv */
// Opcode classifier for the three handled instructions.
// Assumes a registered 14-bit instruction word at its input.
`timescale 1ns/1ps
module opcode_classify (
  // Instruction
  input wire logic [retop_pkg::INSN_W-1:0] insn_in,
  // Class flags
  output logic is_rfi_out,
  output logic is_retlit_out,
  output logic is_ldopt_out
);
  import retop_pkg::*;

  // Pure compare; the two don't-care bits of the literal return are skipped
  assign is_rfi_out = (insn_in == OPC_RETURN_FROM_IRQ);
  assign is_retlit_out = (insn_in[13:RETLIT_HI_POS] == OPC_RETLIT_HI);
  assign is_ldopt_out = (insn_in == OPC_LOAD_OPTION);
endmodule : opcode_classify

/* core/return_and_option_decode.sv */
// Execute logic for return-from-interrupt, return-with-literal and load-option.
// Assumes the fetch unit holds insn_valid_in for one cycle per new word and
// honours stall_out; the stack and status flags live outside.
// Summary of operation
// - Return-from-interrupt pops stack into program counter
// - Return-from-interrupt sets global interrupt enable bit
// - Return-from-interrupt: one word, two cycles, flags kept
// - Load-option copies working register, one cycle
// - Option register also read/written through data memory
// - Return-with-literal loads literal into working register
// - Return-with-literal pops stack, two cycles, flags kept
`timescale 1ns/1ps
module return_and_option_decode (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Instruction stream
  input wire logic [retop_pkg::INSN_W-1:0] insn_in,
  input wire logic insn_valid_in,
  // Return stack
  input wire logic [retop_pkg::PC_W-1:0] stack_top_in,
  // Working register write from the rest of the core
  input wire logic w_wr_in,
  input wire logic [retop_pkg::DATA_W-1:0] w_data_in,
  // Data-memory port for the option register
  input wire logic [7:0] dmem_addr_in,
  input wire logic dmem_wr_in,
  input wire logic [retop_pkg::DATA_W-1:0] dmem_wdata_in,
  // Interrupt controller clears the enable on interrupt entry
  input wire logic irq_en_clear_in,
  // Outputs
  output logic stack_pop_out,
  output logic pc_load_out,
  output logic [retop_pkg::PC_W-1:0] program_counter_out,
  output logic irq_en_set_out,
  output logic global_irq_enable_out,
  output logic [retop_pkg::DATA_W-1:0] working_reg_out,
  output logic [retop_pkg::DATA_W-1:0] option_reg_out,
  output logic [retop_pkg::DATA_W-1:0] dmem_rdata_out,
  output logic stall_out,
  output logic busy_out
);
  import retop_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_t;

  exec_state_t state_r, state_nxt;
  logic is_rfi, is_retlit, is_ldopt;
  logic [DATA_W-1:0] w_r, opt_r, rdata_r;
  logic irq_en_r, pop_r, pcld_r, gset_r, stall_r;
  logic [PC_W-1:0] pc_r;

  // Elaboration checks: the flush logic and field slices assume these sizes
  if (RET_CYCLES != 2) begin : g_bad_cycles
    $error("Return timing supports two cycles only");
  end
  if (INSN_W != 14) begin : g_bad_insn
    $error("Decoder slices assume a 14-bit instruction word");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("Literal and option paths assume an 8-bit data path");
  end
  if (LIT_LSB + DATA_W > RETLIT_HI_POS - 2) begin : g_bad_lit
    $error("Literal field overlaps the opcode field");
  end

  opcode_classify u_cls (
    .insn_in(insn_in),
    .is_rfi_out(is_rfi),
    .is_retlit_out(is_retlit),
    .is_ldopt_out(is_ldopt)
  );

  // Accepted decode only in idle; second cycle is the pipeline flush
  wire take = insn_valid_in && (state_r == ST_IDLE);
  wire do_rfi = take && is_rfi;
  wire do_retlit = take && is_retlit;
  wire do_ldopt = take && is_ldopt;
  wire do_ret = do_rfi || do_retlit;
  wire opt_hit = dmem_addr_in == OPTION_ADDR;
  wire [DATA_W-1:0] lit = insn_in[LIT_LSB +: DATA_W];

  // Two-cycle returns spend one extra cycle flushing the fetched word
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (do_ret) state_nxt = ST_FLUSH;
      ST_FLUSH: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // Pop and PC load pulse in the execute cycle; status flags never touched
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pop_r <= 1'b0;
      pcld_r <= 1'b0;
      pc_r <= '0;
      stall_r <= 1'b0;
    end else begin
      pop_r <= do_ret;
      pcld_r <= do_ret;
      stall_r <= do_ret;
      if (do_ret) pc_r <= stack_top_in;
    end
  end

  // Enable bit: interrupt entry clear loses to a concurrent return-from-interrupt
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_en_r <= IRQ_CTRL_RST[IRQ_EN_BIT];
      gset_r <= 1'b0;
    end else begin
      gset_r <= do_rfi;
      if (do_rfi) irq_en_r <= 1'b1;
      else if (irq_en_clear_in) irq_en_r <= 1'b0;
    end
  end

  // Working register: literal return wins over core write
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) w_r <= WREG_RST;
    else if (do_retlit) w_r <= lit;
    else if (w_wr_in) w_r <= w_data_in;
  end

  // Option register: instruction load has priority over a store
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) opt_r <= OPTION_RST;
    else if (do_ldopt) opt_r <= w_r;
    else if (dmem_wr_in && opt_hit) opt_r <= dmem_wdata_in;
  end

  // Registered read; zero for other addresses
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) rdata_r <= '0;
    else rdata_r <= opt_hit ? opt_r : '0;
  end

  assign stack_pop_out = pop_r;
  assign pc_load_out = pcld_r;
  assign program_counter_out = pc_r;
  assign irq_en_set_out = gset_r;
  assign global_irq_enable_out = irq_en_r;
  assign working_reg_out = w_r;
  assign option_reg_out = opt_r;
  assign dmem_rdata_out = rdata_r;
  assign stall_out = stall_r;
  assign busy_out = stall_r;

  // Checks
  // Return-from-interrupt: pop, counter load and enable pulse together
  a_rfi_pops: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_rfi |=> stack_pop_out && pc_load_out && irq_en_set_out && global_irq_enable_out)
    else $error("rfi did not pop and enable");

  // Both returns load the counter from the stack top seen at decode
  a_rfi_pc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_ret |=> program_counter_out == $past(stack_top_in))
    else $error("pc not loaded from stack");

  // Pops only ever follow an accepted return
  a_pop_source: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    stack_pop_out |-> $past(do_ret))
    else $error("pop without return");

  // Enable can only rise through return-from-interrupt
  a_irq_en_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(global_irq_enable_out) |-> $past(do_rfi))
    else $error("enable set without return");

  // A clear arriving with the return loses, so no interrupt slips in
  a_set_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (do_rfi && irq_en_clear_in) |=> global_irq_enable_out)
    else $error("clear beat the return");

  // Exactly one stall cycle after a return
  a_ret_two: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_ret |=> (stall_out && busy_out) ##1 (!stall_out && !busy_out))
    else $error("return not two cycles");

  // Return-from-interrupt leaves the working register alone
  a_w_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (do_rfi && !w_wr_in) |=> $stable(working_reg_out))
    else $error("rfi touched working register");

  // A word offered in the flush cycle is refused
  a_ret_flush: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_ret ##1 insn_valid_in |=> !stack_pop_out && !pc_load_out)
    else $error("word taken during flush");

  // Load-option is one cycle and copies the working register
  a_ldopt_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_ldopt |=> option_reg_out == $past(w_r) && !stall_out)
    else $error("option load wrong");

  // Load-option never disturbs the stack
  a_ldopt_nopop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_ldopt |=> !stack_pop_out && !pc_load_out)
    else $error("option load popped stack");

  // Data-memory store to the option address lands
  a_opt_store: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (dmem_wr_in && opt_hit && !do_ldopt) |=> option_reg_out == $past(dmem_wdata_in))
    else $error("option store lost");

  // Literal return: literal into working register, stack popped
  a_retlit_w: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    do_retlit |=> working_reg_out == $past(insn_in[7:0]) && stack_pop_out)
    else $error("literal not loaded");

  // Fixed bits alone select the literal return; bits 9:8 play no part
  a_dontcare: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (take && insn_in[13:10] == OPC_RETLIT_HI) |=> working_reg_out == $past(insn_in[7:0])
      && pc_load_out)
    else $error("dont-care bits decoded");

  // Every output but irq_en_set_out and busy_out is back at its reset value on the first free edge
  a_reset_clean: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> !stack_pop_out && !pc_load_out && !stall_out
      && !global_irq_enable_out && program_counter_out == '0 && dmem_rdata_out == '0
      && working_reg_out == WREG_RST && option_reg_out == OPTION_RST)
    else $error("outputs not reset");

  // Main scenarios
  c_rfi: cover property (@(posedge clk_in) do_rfi);
  c_retlit: cover property (@(posedge clk_in) do_retlit);
  c_ldopt: cover property (@(posedge clk_in) do_ldopt);
  c_back: cover property (@(posedge clk_in) do_ret ##2 do_ret);
  c_set_wins: cover property (@(posedge clk_in) do_rfi && irq_en_clear_in);
endmodule : return_and_option_decode

/* verification/tb_top.sv */
// Self-checking bench for the return and option-load decoder.
// Assumes the block alone; the bench plays fetch unit, stack and data memory.
`timescale 1ns/1ps
module tb_top;
  import retop_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [INSN_W-1:0] insn_in = '0;
  logic insn_valid_in = 1'b0;
  logic [PC_W-1:0] stack_top_in = '0;
  logic w_wr_in = 1'b0;
  logic [DATA_W-1:0] w_data_in = '0;
  logic [7:0] dmem_addr_in = '0;
  logic dmem_wr_in = 1'b0;
  logic [DATA_W-1:0] dmem_wdata_in = '0;
  logic irq_en_clear_in = 1'b0;
  logic stack_pop_out, pc_load_out, irq_en_set_out, global_irq_enable_out;
  logic stall_out, busy_out;
  logic [PC_W-1:0] program_counter_out;
  logic [DATA_W-1:0] working_reg_out, option_reg_out, dmem_rdata_out;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] lits [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  return_and_option_decode i_dut (.clk_in, .sys_rst_in, .insn_in, .insn_valid_in,
    .stack_top_in, .w_wr_in, .w_data_in, .dmem_addr_in, .dmem_wr_in, .dmem_wdata_in,
    .irq_en_clear_in, .stack_pop_out, .pc_load_out, .program_counter_out, .irq_en_set_out,
    .global_irq_enable_out, .working_reg_out, .option_reg_out, .dmem_rdata_out,
    .stall_out, .busy_out);
  initial forever #2 clk_in = ~clk_in;
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // Whole run is a few dozen cycles; the ceiling only catches a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk_v(input logic [12:0] g, input logic [12:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task automatic chk_b(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk_b
  // Inputs always move 1 ns after the edge, never on it
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  // Offer one word for one edge; returns in the answer cycle
  task automatic issue(input logic [13:0] w, input logic clr);
    tick();
    insn_in = w;
    insn_valid_in = 1'b1;
    irq_en_clear_in = clr;
    tick();
    insn_valid_in = 1'b0;
    irq_en_clear_in = 1'b0;
  endtask : issue
  task automatic test_rfi;
    stack_top_in = 13'h1ABC;
    tick();
    insn_in = OPC_RETURN_FROM_IRQ;
    insn_valid_in = 1'b1;
    irq_en_clear_in = 1'b1; // clear in same cycle must lose
    tick();
    irq_en_clear_in = 1'b0;
    // Valid stays up: the next word lands in the flush cycle and is dropped
    insn_in = 14'h34AA;
    stack_top_in = 13'h0555;
    chk_b(stack_pop_out, 1);
    chk_v(program_counter_out, 13'h1ABC);
    chk_b(global_irq_enable_out, 1);
    chk_b(irq_en_set_out, 1);
    chk_b(stall_out, 1);
    chk_b(busy_out, 1);
    tick();
    insn_valid_in = 1'b0;
    chk_b(stall_out, 0);
    chk_b(busy_out, 0);
    chk_b(stack_pop_out, 0);
    chk_b(irq_en_set_out, 0);
    chk_v(program_counter_out, 13'h1ABC);
    chk_v(working_reg_out, WREG_RST);
    $display("test rfi done");
  endtask : test_rfi
  task automatic test_retlit;
    for (int x = 0; x < 4; x++) begin
      stack_top_in = 13'h0100 + 13'(x);
      w_wr_in = (x == 2); // literal must beat a core write
      w_data_in = 8'h33;
      issue({4'hD, 2'(x), lits[x]}, 1'b0);
      w_wr_in = 1'b0;
      chk_v(working_reg_out, lits[x]);
      chk_v(program_counter_out, 13'h0100 + 13'(x));
      chk_b(pc_load_out, 1);
      chk_b(stack_pop_out, 1);
      chk_b(irq_en_set_out, 0);
      chk_b(stall_out, 1);
      tick();
      chk_b(stall_out, 0);
    end
    $display("test retlit done");
  endtask : test_retlit
  task automatic test_option;
    w_wr_in = 1'b1;
    w_data_in = 8'h3C;
    insn_in = OPC_LOAD_OPTION;
    tick();
    insn_valid_in = 1'b1;
    w_data_in = 8'hC3;
    dmem_addr_in = OPTION_ADDR;
    dmem_wr_in = 1'b1; // store in the same cycle must lose
    dmem_wdata_in = 8'h96;
    tick();
    chk_v(option_reg_out, 8'h3C);
    chk_b(stall_out, 0);
    w_wr_in = 1'b0;
    tick();
    insn_valid_in = 1'b0;
    chk_v(option_reg_out, 8'hC3);
    tick();
    // Read is registered: it shows the value from before this store
    chk_v(option_reg_out, 8'h96);
    chk_v(dmem_rdata_out, 8'hC3);
    dmem_addr_in = 8'h80;
    tick();
    dmem_wr_in = 1'b0;
    chk_v(option_reg_out, 8'h96);
    chk_v(dmem_rdata_out, 8'h00);
    dmem_addr_in = OPTION_ADDR;
    tick();
    chk_v(dmem_rdata_out, 8'h96);
    $display("test option done");
  endtask : test_option
  // Reset in mid-run with a return on offer; every output but pc_load_out, irq_en_set_out and busy_out must come back clean
  task automatic test_reset;
    tick();
    sys_rst_in = 1'b1;
    insn_in = OPC_RETURN_FROM_IRQ;
    insn_valid_in = 1'b1;
    repeat (2) tick();
    sys_rst_in = 1'b0;
    insn_valid_in = 1'b0;
    chk_v(option_reg_out, OPTION_RST);
    chk_v(working_reg_out, WREG_RST);
    chk_v(program_counter_out, 13'h0000);
    chk_b(global_irq_enable_out, 0);
    chk_b(stack_pop_out, 0);
    chk_b(stall_out, 0);
    chk_v(dmem_rdata_out, 8'h00);
    tick();
    chk_b(stack_pop_out, 0);
    chk_v(dmem_rdata_out, OPTION_RST);
    $display("test reset done");
  endtask : test_reset
  initial begin
    repeat (5) tick();
    sys_rst_in = 1'b0;
    chk_v(option_reg_out, OPTION_RST);
    chk_b(global_irq_enable_out, 0);
    test_rfi();
    test_retlit();
    test_option();
    test_reset();
    conclude();
  end
endmodule : tb_top
